// ===== inc/sbfr_pkg.sv
// Purpose: constants and state type of the serial boot read command block
// Assumes: byte values are the codes seen on the serial link
// Notes: addresses and counts are 24 bits wide on the link
package sbfr_pkg;
    // ----------------------------------------
    // Link codes and counter limits
    // ----------------------------------------
    localparam logic [7:0] MATCH1_A = 8'h86;
    localparam logic [7:0] MATCH1_B = 8'h30;
    localparam logic [7:0] MATCH2_A = 8'h79;
    localparam logic [7:0] MATCH2_B = 8'hCF;
    localparam logic [7:0] OPC_READ = 8'h40;
    localparam logic [7:0] ERR_FRAME = 8'hA1;
    localparam logic [7:0] ERR_CMD = 8'hA3;
    localparam logic [7:0] ERR_SEC = 8'h63;
    localparam logic [1:0] ERR_LAST = 2'h2;
    localparam logic [1:0] FIELD_LAST = 2'h2;
    // ----------------------------------------
    // Blank check window and limits
    // ----------------------------------------
    localparam logic [23:0] BLANK_LO = 24'h00FFE0;
    localparam logic [23:0] BLANK_HI = 24'h00FFFF;
    localparam logic [7:0] BLANK_VAL = 8'hFF;
    localparam logic [23:0] COUNT_MIN = 24'h000000;
    localparam logic [15:0] SUM_RST = 16'h0000;
    localparam int MIN_BIT = 4;
    typedef enum logic [4:0] {
        S_ABW, S_ABL, S_ABH, S_ABE, S_M2, S_OPC, S_PCA, S_PCB, S_CHK,
        S_SCAN, S_SCW, S_PWD, S_RSA, S_CNT, S_RNG, S_RD, S_RDW,
        S_CSH, S_CSL, S_SEND, S_ERR, S_DEAD
    } sbfr_st_t;
endpackage

// ===== core/sbfr_core.sv
// Purpose: serial boot flash read command: autobaud, match, read, checksum
// Assumes: rxd and memory answers synchronous to clk; memory read latency 1
// Notes: password checking itself sits outside, behind pw_* ports
`timescale 1ns/1ps
// Operation
// R1: first byte's high run sets the bit period, its low run checks the byte, before any reply
// R2: every later byte both ways is timed by the measured bit period
// R3: first match byte 0x86 or 0x30 echoed when recognised, else silence
// R4: second match byte 0x79 or 0xCF echoed when accepted, else silence
// R5: command 0x40 is echoed when accepted
// R6: rejected command sends one error code three times then idles
// R7: controller sends password count address, three bytes, no reply
// R8: controller sends compare address and password string, no reply
// R9: all 0xFF at 0xFFE0..0xFFFF skips the password string
// R10: a bad password address field idles the block
// R11: security enabled or password failure idles the block
// R12: framing error in password fields or string idles the block
// R13: controller must reset and restart boot mode after an idle
// R14: controller sends the read start address, three bytes, no reply
// R15: controller sends the byte count, three bytes, no reply
// R16: zero or oversize byte count idles without data
// R17: requested memory bytes are sent in order from the start address
// R18: sixteen-bit checksum follows, high byte first
// R19: after the checksum the next command byte is awaited
module sbfr_core #(
    parameter int CW = 16,
    parameter logic [23:0] MEM_SIZE = 24'h010000
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset,
    input wire logic ce,
    // Serial link
    input wire logic rxd,
    output logic txd_ff,
    // Memory read port
    output logic mem_rd_ff,
    output logic [23:0] mem_addr_ff,
    input wire logic [7:0] mem_rdata,
    // Password checker
    input wire logic sec_en,
    input wire logic pw_addr_ok,
    input wire logic pw_done,
    input wire logic pw_ok,
    output logic [23:0] pw_cnt_addr_ff,
    output logic [23:0] pw_cmp_addr_ff,
    output logic pw_vld_ff,
    output logic [7:0] pw_byte_ff,
    // Status
    output logic idle_ff
);
    sbfr_pkg::sbfr_st_t st_ff, ret_ff;
    logic [CW-1:0] bit_ff, lcnt_ff, hcnt_ff;
    logic [7:0] txb_ff, m1_ff, err_ff;
    logic [23:0] sh_ff, addr_ff, cnt_ff;
    logic [1:0] nb_ff, ecnt_ff;
    logic [15:0] sum_ff;
    logic blank_ff, mem_vld_ff;
    logic rx_busy_ff, rx_vld_ff, rx_ferr_ff;
    logic [3:0] rx_idx_ff, tx_idx_ff;
    logic [CW-1:0] rx_cnt_ff, tx_cnt_ff;
    logic [7:0] rx_sh_ff;
    logic tx_busy_ff;
    logic [9:0] tx_sh_ff;

    // ----------------------------------------
    // Decode
    // ----------------------------------------
    wire [CW+1:0] l4_w = {lcnt_ff, 2'b00};
    wire [CW+1:0] h3_w = {2'b00, hcnt_ff} + {1'b0, hcnt_ff, 1'b0};
    wire [CW+1:0] h5_w = {hcnt_ff, 2'b00} + {2'b00, hcnt_ff};
    wire [CW+1:0] h8_w = {hcnt_ff[CW-2:0], 3'b000};
    wire [CW+1:0] h12_w = {hcnt_ff, 2'b00} + h8_w;
    wire is86_w = (l4_w >= h3_w) && (l4_w <= h5_w);
    wire is30_w = (l4_w >= h8_w) && (l4_w <= h12_w);
    wire [CW-1:0] half_w = hcnt_ff >> 1;
    wire baud_ok_w = (half_w >= CW'(sbfr_pkg::MIN_BIT));
    wire [CW-1:0] tail_w = bit_ff + (bit_ff >> 1);
    wire rx_en_w = (st_ff != sbfr_pkg::S_ABW) && (st_ff != sbfr_pkg::S_ABL)
        && (st_ff != sbfr_pkg::S_ABH) && (st_ff != sbfr_pkg::S_ABE);
    wire rx_tick_w = rx_busy_ff && (rx_cnt_ff == '0);
    wire tx_go_w = (st_ff == sbfr_pkg::S_SEND) && !tx_busy_ff;
    wire tx_tick_w = tx_busy_ff && (tx_cnt_ff == '0);
    wire [7:0] rxd8_w = rx_sh_ff;
    wire m2_ok_w = !rx_ferr_ff && ((rxd8_w == sbfr_pkg::MATCH2_A)
        || (rxd8_w == sbfr_pkg::MATCH2_B));
    wire [23:0] field_w = {sh_ff[15:0], rxd8_w};
    wire scan_ok_w = blank_ff && (mem_rdata == sbfr_pkg::BLANK_VAL);
    wire [24:0] end_w = {1'b0, addr_ff} + {1'b0, cnt_ff};
    wire range_bad_w = (cnt_ff == sbfr_pkg::COUNT_MIN)
        || (cnt_ff > MEM_SIZE) || (end_w > {1'b0, MEM_SIZE});

    // ----------------------------------------
    // Receiver, timed by measured bit period
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rx_busy_ff <= 1'b0;
            rx_vld_ff <= 1'b0;
            rx_ferr_ff <= 1'b0;
            rx_idx_ff <= 4'h0;
            rx_cnt_ff <= '0;
            rx_sh_ff <= 8'h00;
        end else if (ce) begin
            rx_vld_ff <= 1'b0;
            if (!rx_busy_ff) begin
                if (rx_en_w && !rxd) begin
                    rx_busy_ff <= 1'b1;
                    rx_idx_ff <= 4'h0;
                    rx_cnt_ff <= bit_ff >> 1; // see R2
                end
            end else if (rx_tick_w) begin
                rx_cnt_ff <= bit_ff - CW'(1); // see R2
                rx_idx_ff <= rx_idx_ff + 4'h1;
                if (rx_idx_ff == 4'h0 && rxd) begin
                    // Glitch, not a start bit
                    rx_busy_ff <= 1'b0;
                end else if (rx_idx_ff == 4'h9) begin
                    rx_busy_ff <= 1'b0;
                    rx_vld_ff <= 1'b1;
                    rx_ferr_ff <= !rxd;
                end else if (rx_idx_ff != 4'h0) begin
                    rx_sh_ff <= {rxd, rx_sh_ff[7:1]};
                end
            end else begin
                rx_cnt_ff <= rx_cnt_ff - CW'(1);
            end
        end
    end

    // ----------------------------------------
    // Transmitter
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            tx_busy_ff <= 1'b0;
            tx_sh_ff <= 10'h3FF;
            tx_idx_ff <= 4'h0;
            tx_cnt_ff <= '0;
            txd_ff <= 1'b1;
        end else if (ce) begin
            if (tx_go_w) begin
                tx_busy_ff <= 1'b1;
                tx_sh_ff <= {1'b1, txb_ff, 1'b0};
                tx_idx_ff <= 4'h0;
                tx_cnt_ff <= '0;
            end else if (tx_tick_w) begin
                if (tx_idx_ff == 4'hA) begin
                    tx_busy_ff <= 1'b0;
                end else begin
                    txd_ff <= tx_sh_ff[0];
                    tx_sh_ff <= {1'b1, tx_sh_ff[9:1]};
                    tx_idx_ff <= tx_idx_ff + 4'h1;
                    tx_cnt_ff <= bit_ff - CW'(1); // see R2
                end
            end else if (tx_busy_ff) begin
                tx_cnt_ff <= tx_cnt_ff - CW'(1);
            end
        end
    end

    // ----------------------------------------
    // Command sequencer
    // ----------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            st_ff <= sbfr_pkg::S_ABW;
            ret_ff <= sbfr_pkg::S_ABW;
            bit_ff <= '0;
            lcnt_ff <= '0;
            hcnt_ff <= '0;
            txb_ff <= 8'h00;
            m1_ff <= 8'h00;
            err_ff <= 8'h00;
            sh_ff <= 24'h000000;
            addr_ff <= 24'h000000;
            cnt_ff <= 24'h000000;
            nb_ff <= 2'h0;
            ecnt_ff <= 2'h0;
            sum_ff <= sbfr_pkg::SUM_RST;
            blank_ff <= 1'b0;
            mem_vld_ff <= 1'b0;
            mem_rd_ff <= 1'b0;
            mem_addr_ff <= 24'h000000;
            pw_cnt_addr_ff <= 24'h000000;
            pw_cmp_addr_ff <= 24'h000000;
            pw_vld_ff <= 1'b0;
            pw_byte_ff <= 8'h00;
            idle_ff <= 1'b0;
        end else if (ce) begin
            mem_rd_ff <= 1'b0;
            mem_vld_ff <= mem_rd_ff;
            pw_vld_ff <= 1'b0;
            idle_ff <= (st_ff == sbfr_pkg::S_DEAD);
            case (st_ff)
                sbfr_pkg::S_ABW: begin
                    // Edge cycle counts too, so runs measure whole bits
                    lcnt_ff <= rxd ? '0 : CW'(1); // see R1
                    hcnt_ff <= '0;
                    if (!rxd)
                        st_ff <= sbfr_pkg::S_ABL;
                end
                sbfr_pkg::S_ABL: begin
                    // Saturate rather than wrap on very slow links
                    if (rxd) begin
                        hcnt_ff <= CW'(1); // see R1
                        st_ff <= sbfr_pkg::S_ABH;
                    end else if (lcnt_ff != '1) begin
                        lcnt_ff <= lcnt_ff + CW'(1); // see R1
                    end
                end
                sbfr_pkg::S_ABH: begin
                    if (!rxd) begin
                        // 0x86 has 2 bits low then 2 high, 0x30 5 then 2
                        bit_ff <= half_w; // see R1
                        lcnt_ff <= '0;
                        if (baud_ok_w && (is86_w || is30_w)) begin
                            m1_ff <= is86_w ? sbfr_pkg::MATCH1_A
                                : sbfr_pkg::MATCH1_B; // see R3
                            st_ff <= sbfr_pkg::S_ABE;
                        end else begin
                            st_ff <= sbfr_pkg::S_DEAD; // see R3
                        end
                    end else if (hcnt_ff != '1) begin
                        hcnt_ff <= hcnt_ff + CW'(1);
                    end
                end
                sbfr_pkg::S_ABE: begin
                    // Wait out the rest of the byte: a long high run
                    lcnt_ff <= rxd ? lcnt_ff + CW'(1) : '0;
                    if (rxd && lcnt_ff >= tail_w) begin
                        txb_ff <= m1_ff; // see R3
                        ret_ff <= sbfr_pkg::S_M2;
                        st_ff <= sbfr_pkg::S_SEND;
                    end
                end
                sbfr_pkg::S_M2: if (rx_vld_ff) begin
                    txb_ff <= rxd8_w;
                    ret_ff <= sbfr_pkg::S_OPC;
                    st_ff <= m2_ok_w ? sbfr_pkg::S_SEND
                        : sbfr_pkg::S_DEAD; // see R4
                end
                sbfr_pkg::S_OPC: if (rx_vld_ff) begin
                    nb_ff <= 2'h0;
                    ecnt_ff <= 2'h0;
                    if (rx_ferr_ff) begin
                        err_ff <= sbfr_pkg::ERR_FRAME; // see R6
                        st_ff <= sbfr_pkg::S_ERR;
                    end else if (rxd8_w != sbfr_pkg::OPC_READ) begin
                        err_ff <= sbfr_pkg::ERR_CMD; // see R6
                        st_ff <= sbfr_pkg::S_ERR;
                    end else begin
                        txb_ff <= sbfr_pkg::OPC_READ; // see R5
                        ret_ff <= sbfr_pkg::S_PCA;
                        st_ff <= sbfr_pkg::S_SEND;
                    end
                end
                sbfr_pkg::S_PCA, sbfr_pkg::S_PCB, sbfr_pkg::S_RSA,
                sbfr_pkg::S_CNT: if (rx_vld_ff) begin
                    // Fields are silent, MSB first; see R7 R8 R14 R15
                    sh_ff <= field_w;
                    nb_ff <= nb_ff + 2'h1;
                    if (rx_ferr_ff) begin
                        st_ff <= sbfr_pkg::S_DEAD; // see R12
                    end else if (nb_ff == sbfr_pkg::FIELD_LAST) begin
                        nb_ff <= 2'h0;
                        case (st_ff)
                            sbfr_pkg::S_PCA: begin
                                pw_cnt_addr_ff <= field_w;
                                st_ff <= sbfr_pkg::S_PCB;
                            end
                            sbfr_pkg::S_PCB: begin
                                pw_cmp_addr_ff <= field_w;
                                st_ff <= sbfr_pkg::S_CHK;
                            end
                            sbfr_pkg::S_RSA: begin
                                addr_ff <= field_w;
                                st_ff <= sbfr_pkg::S_CNT;
                            end
                            default: begin
                                cnt_ff <= field_w;
                                st_ff <= sbfr_pkg::S_RNG;
                            end
                        endcase
                    end
                end
                sbfr_pkg::S_CHK: begin
                    addr_ff <= sbfr_pkg::BLANK_LO;
                    blank_ff <= 1'b1;
                    if (sec_en || !pw_addr_ok)
                        st_ff <= sbfr_pkg::S_DEAD; // see R10 R11
                    else
                        st_ff <= sbfr_pkg::S_SCAN;
                end
                sbfr_pkg::S_SCAN, sbfr_pkg::S_RD: begin
                    mem_rd_ff <= 1'b1;
                    mem_addr_ff <= addr_ff; // see R17
                    st_ff <= (st_ff == sbfr_pkg::S_RD) ? sbfr_pkg::S_RDW
                        : sbfr_pkg::S_SCW;
                end
                sbfr_pkg::S_SCW: if (mem_vld_ff) begin
                    blank_ff <= scan_ok_w;
                    addr_ff <= addr_ff + 24'h000001;
                    if (addr_ff != sbfr_pkg::BLANK_HI)
                        st_ff <= sbfr_pkg::S_SCAN;
                    else if (scan_ok_w)
                        st_ff <= sbfr_pkg::S_RSA; // see R9
                    else
                        st_ff <= sbfr_pkg::S_PWD;
                end
                sbfr_pkg::S_PWD: begin
                    if (pw_done) begin
                        st_ff <= pw_ok ? sbfr_pkg::S_RSA
                            : sbfr_pkg::S_DEAD; // see R11
                    end else if (rx_vld_ff) begin
                        if (rx_ferr_ff) begin
                            st_ff <= sbfr_pkg::S_DEAD; // see R12
                        end else begin
                            pw_vld_ff <= 1'b1;
                            pw_byte_ff <= rxd8_w;
                        end
                    end
                end
                sbfr_pkg::S_RNG: begin
                    sum_ff <= sbfr_pkg::SUM_RST;
                    st_ff <= range_bad_w ? sbfr_pkg::S_DEAD
                        : sbfr_pkg::S_RD; // see R16
                end
                sbfr_pkg::S_RDW: if (mem_vld_ff) begin
                    txb_ff <= mem_rdata; // see R17
                    sum_ff <= sum_ff + {8'h00, mem_rdata};
                    addr_ff <= addr_ff + 24'h000001;
                    cnt_ff <= cnt_ff - 24'h000001;
                    ret_ff <= (cnt_ff == 24'h000001) ? sbfr_pkg::S_CSH
                        : sbfr_pkg::S_RD;
                    st_ff <= sbfr_pkg::S_SEND;
                end
                sbfr_pkg::S_CSH: begin
                    txb_ff <= sum_ff[15:8]; // see R18
                    ret_ff <= sbfr_pkg::S_CSL;
                    st_ff <= sbfr_pkg::S_SEND;
                end
                sbfr_pkg::S_CSL: begin
                    txb_ff <= sum_ff[7:0]; // see R18
                    ret_ff <= sbfr_pkg::S_OPC; // see R19
                    st_ff <= sbfr_pkg::S_SEND;
                end
                sbfr_pkg::S_ERR: begin
                    txb_ff <= err_ff;
                    ecnt_ff <= ecnt_ff + 2'h1;
                    ret_ff <= (ecnt_ff == sbfr_pkg::ERR_LAST)
                        ? sbfr_pkg::S_DEAD : sbfr_pkg::S_ERR; // see R6
                    st_ff <= sbfr_pkg::S_SEND;
                end
                sbfr_pkg::S_SEND: if (tx_go_w)
                    st_ff <= ret_ff;
                // Only a reset leaves this state
                sbfr_pkg::S_DEAD: st_ff <= sbfr_pkg::S_DEAD;
                default: st_ff <= sbfr_pkg::S_DEAD;
            endcase
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    AST_SILENT_BAUD: assert property (@(posedge clk) disable iff (reset) // see R1
        !rx_en_w |-> (txd_ff && !tx_busy_ff))
        else $error("reply before baud measured");
    AST_TX_PERIOD: assert property (@(posedge clk) disable iff (reset) // see R2
        tx_busy_ff |-> (tx_cnt_ff < bit_ff || tx_idx_ff == 4'h0))
        else $error("tx bit longer than measured period");
    AST_M1_FAIL: assert property (@(posedge clk) disable iff (reset) // see R3
        (ce && st_ff == sbfr_pkg::S_ABH && !rxd && !(is86_w || is30_w))
        |=> st_ff == sbfr_pkg::S_DEAD)
        else $error("bad match byte not rejected");
    AST_M2_ECHO: assert property (@(posedge clk) disable iff (reset) // see R4
        (ce && st_ff == sbfr_pkg::S_M2 && rx_vld_ff && m2_ok_w)
        |=> (st_ff == sbfr_pkg::S_SEND && txb_ff == $past(rx_sh_ff)))
        else $error("second match byte not echoed");
    AST_OPC_ECHO: assert property (@(posedge clk) disable iff (reset) // see R5
        (ce && st_ff == sbfr_pkg::S_OPC && rx_vld_ff && !rx_ferr_ff
        && rx_sh_ff == sbfr_pkg::OPC_READ)
        |=> (txb_ff == sbfr_pkg::OPC_READ && ret_ff == sbfr_pkg::S_PCA))
        else $error("read command not echoed");
    AST_ERR_THRICE: assert property (@(posedge clk) disable iff (reset) // see R6
        (st_ff == sbfr_pkg::S_ERR && ecnt_ff == sbfr_pkg::ERR_LAST && ce)
        |=> ret_ff == sbfr_pkg::S_DEAD)
        else $error("error code not limited to three");
    AST_PW_ADDR: assert property (@(posedge clk) disable iff (reset) // see R10
        (ce && st_ff == sbfr_pkg::S_CHK && (!pw_addr_ok || sec_en))
        |=> st_ff == sbfr_pkg::S_DEAD)
        else $error("password address error not fatal");
    AST_FRAME_PW: assert property (@(posedge clk) disable iff (reset) // see R12
        (ce && rx_vld_ff && rx_ferr_ff && (st_ff == sbfr_pkg::S_PCA
        || st_ff == sbfr_pkg::S_PCB || st_ff == sbfr_pkg::S_PWD) && !pw_done)
        |=> st_ff == sbfr_pkg::S_DEAD)
        else $error("framing error in password phase not fatal");
    AST_RANGE: assert property (@(posedge clk) disable iff (reset) // see R16
        (ce && st_ff == sbfr_pkg::S_RNG && cnt_ff == 24'h000000)
        |=> st_ff == sbfr_pkg::S_DEAD)
        else $error("zero count not rejected");
    AST_BLANK_SKIP: assert property (@(posedge clk) disable iff (reset) // see R9
        (st_ff == sbfr_pkg::S_RSA && blank_ff) |-> !pw_vld_ff)
        else $error("password taken on blank part");
    AST_SUM_NEXT: assert property (@(posedge clk) disable iff (reset) // see R19
        (ce && st_ff == sbfr_pkg::S_CSL) |=> ret_ff == sbfr_pkg::S_OPC)
        else $error("no return to command wait after checksum");
endmodule

// ===== verif/sbfr_host.sv
// Purpose: serial controller model on the far side of the boot link
// Assumes: 8N1 frames, LSB first, bit period of BP clock cycles
// Notes: BP also fixes what the autobaud of the first byte measures
`timescale 1ns/1ps
module sbfr_host #(
    parameter int BP = 8
) (
    // Clock
    input wire logic clk,
    // Serial link
    output logic rxd,
    input wire logic txd
);
    // ----------------------------------------
    // Frame tasks
    // ----------------------------------------
    initial rxd = 1'b1;
    // Full stop bit; a low stop level forces a framing fault
    task automatic send(input logic [7:0] b, input logic stp = 1'b1);
        logic [9:0] f;
        f = {stp, b, 1'b0};
        repeat (BP / 2) @(negedge clk);
        for (int i = 0; i < 10; i++) begin
            rxd = f[i];
            repeat (BP) @(negedge clk);
        end
        rxd = 1'b1;
    endtask
    task automatic recv(output logic [7:0] b, output logic ok);
        int n;
        n = 0;
        ok = 1'b0;
        b = 8'h00;
        while (txd !== 1'b0 && n < 40 * BP) begin
            @(negedge clk);
            n++;
        end
        if (txd === 1'b0) begin
            repeat (BP / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BP) @(negedge clk);
                b[i] = txd;
            end
            repeat (BP) @(negedge clk);
            ok = (txd === 1'b1);
        end
    endtask
    task automatic quiet(input int n, output logic ok);
        ok = 1'b1;
        repeat (n) begin
            @(negedge clk);
            if (txd !== 1'b1) ok = 1'b0;
        end
    endtask
endmodule

// ===== verif/tb.sv
// Purpose: self-checking bench of the serial boot read command
// Assumes: memory answers one cycle after mem_rd_ff
// Notes: reads run as table rows, faults are hand-written after them
`timescale 1ns/1ps
module tb;
    // ----------------------------------------
    // Signals and models
    // ----------------------------------------
    localparam int BP = 8;
    logic clk, reset, rxd, txd, mem_rd, idle, ok, nb, pw_vld;
    logic sec_en, pw_addr_ok, pw_done, pw_ok;
    logic [7:0] mem_rdata, pw_byte, b;
    logic [23:0] mem_addr, pw_cnt, pw_cmp;
    logic [15:0] sum;
    int errors, cmp_count;
    int pw_n;
    typedef struct {logic [23:0] start; logic [23:0] cnt;} sbfr_row_t;
    sbfr_row_t rows [3] = '{'{24'h000010, 24'h000004},
        '{24'h00FFFE, 24'h000002}, '{24'h000000, 24'h000001}};
    sbfr_core dut (.clk(clk), .reset(reset), .ce(1'b1), .rxd(rxd),
        .txd_ff(txd), .mem_rd_ff(mem_rd), .mem_addr_ff(mem_addr),
        .mem_rdata(mem_rdata), .sec_en(sec_en), .pw_addr_ok(pw_addr_ok),
        .pw_done(pw_done), .pw_ok(pw_ok), .pw_cnt_addr_ff(pw_cnt),
        .pw_cmp_addr_ff(pw_cmp), .pw_vld_ff(pw_vld), .pw_byte_ff(pw_byte),
        .idle_ff(idle));
    sbfr_host #(.BP(BP)) host (.clk(clk), .rxd(rxd), .txd(txd));
    // Password window reads blank unless nb is set
    function automatic logic [7:0] mem_val(input logic [23:0] a);
        if (a >= 24'h00FFE0) return nb ? 8'h00 : 8'hFF;
        return a[7:0] ^ a[15:8] ^ 8'h5A;
    endfunction
    always @(posedge clk) if (mem_rd) mem_rdata <= mem_val(mem_addr);
    // Password byte pulses since the last reset
    always @(posedge clk) begin
        if (reset)
            pw_n <= 0;
        else if (pw_vld)
            pw_n <= pw_n + 1;
    end
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic chk(input string nm, input logic [23:0] e,
                       input logic [23:0] g);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic expect_byte(input string nm, input logic [7:0] e);
        host.recv(b, ok);
        chk(nm, {16'h0001, e}, {15'h0000, ok, b});
    endtask
    task automatic send24(input logic [23:0] v);
        for (int i = 2; i >= 0; i--) host.send(v[i*8 +: 8]);
    endtask
    task automatic open_link(input logic [7:0] m1, input logic [7:0] m2);
        reset = 1'b1;
        repeat (2) @(negedge clk);
        reset = 1'b0;
        @(negedge clk);
        chk("txd_idle", 24'h000001, {23'h0, txd});
        host.send(m1);
        expect_byte("echo1", m1);
        host.send(m2);
        if (m2 == 8'h79 || m2 == 8'hCF) expect_byte("echo2", m2);
    endtask
    task automatic head();
        host.send(8'h40);
        expect_byte("echo_opc", 8'h40);
        send24(24'h00FFF0);
        send24(24'h00FFE0);
        repeat (8 * BP) @(negedge clk);
    endtask
    task automatic print_verdict();
        if (errors == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // ----------------------------------------
    // Sequence
    // ----------------------------------------
    initial begin
        repeat (60000) @(posedge clk);
        errors++;
        print_verdict();
    end
    initial begin
        {reset, pw_addr_ok, sec_en, pw_done, pw_ok, nb} = 6'h30;
        errors = 0;
        cmp_count = 0;
        open_link(8'h86, 8'h79);
        foreach (rows[r]) begin
            head();
            chk("pw_cnt", 24'h00FFF0, pw_cnt);
            chk("pw_cmp", 24'h00FFE0, pw_cmp);
            send24(rows[r].start);
            send24(rows[r].cnt);
            sum = 16'h0000;
            for (int i = 0; i < rows[r].cnt; i++) begin
                sum += mem_val(24'(rows[r].start + i));
                expect_byte("data", mem_val(24'(rows[r].start + i)));
            end
            expect_byte("sum_hi", sum[15:8]);
            expect_byte("sum_lo", sum[7:0]);
        end
        chk("pw_vld", 24'h000000, 24'(pw_n));
        for (int k = 0; k < 9; k++) begin
            sec_en = (k == 5);
            pw_addr_ok = (k != 6);
            nb = (k == 8);
            open_link(k[0] ? 8'h30 : 8'h86,
                k == 0 ? 8'h12 : (k[1] ? 8'hCF : 8'h79));
            if (k == 1 || k == 2) begin
                host.send(k == 1 ? 8'h41 : 8'h40, k == 1);
                repeat (3) expect_byte("err", k == 1 ? 8'hA3 : 8'hA1);
            end else if (k == 7) begin
                host.send(8'h40);
                expect_byte("echo_opc", 8'h40);
                host.send(8'h00, 1'b0);
            end else if (k > 2) begin
                head();
                if (k < 5) send24(k == 3 ? 24'h000000 : 24'h00FFFF);
                if (k < 5) send24(k == 3 ? 24'h000000 : 24'h000002);
                if (k == 8) host.send(8'h5C);
                repeat (BP) @(negedge clk);
                if (k == 8) chk("pw_byte", 24'h00005C, {16'h0, pw_byte});
                if (k == 8) chk("pw_vld", 24'h000001, 24'(pw_n));
                {pw_done, pw_ok} = {k == 8, 1'b0};
            end
            host.send(8'h40);
            host.quiet(20 * BP, ok);
            chk("silent", 24'h000001, {23'h0, ok});
            chk("idle", 24'h000001, {23'h0, idle});
            pw_done = 1'b0;
        end
        print_verdict();
    end
endmodule
